// ### clrp_pkg.sv
/*
 * Constants and types shared by the converter link receive ports block.
 * Assumes a single 250 MHz core clock and fixed lane count.
 */
package clrp_pkg;
	// ==========================================================
	// Structure
	localparam int LANES = 4;
	localparam int WORD_66 = 64;
	localparam int WORD_8B = 32;
	localparam int HDR_W = 2;
	localparam int BYTES_8B = 4;
	localparam int CMD_W = 19;
	localparam int CRC_CMD_W = 7;
	localparam int BLOCKS_PER_MB = 32;
	localparam int MB_PER_EMB = 4;
	localparam int MB_CNT_W = 5;
	localparam int EMB_CNT_W = 2;
	// ==========================================================
	// Timing
	localparam int CLOCK_MHZ = 250;
	localparam int LINE_DIV_66 = 66;
	localparam int LINE_DIV_8B = 40;
	localparam int COMMA_GOOD_WORDS = 4;
	localparam int COMMA_CNT_W = 3;
	// ==========================================================
	// Sync header and comma codes
	localparam logic [1:0] HDR_DATA = 2'h1;
	localparam logic [1:0] HDR_CTRL = 2'h2;
	localparam logic [7:0] K28_5 = 8'hBC;
	// ==========================================================
	// Reset values
	localparam logic [MB_CNT_W-1:0] BLK_RST = 5'h00;
	localparam logic [EMB_CNT_W-1:0] EMB_RST = 2'h0;
	// ==========================================================
	// Types
	typedef enum logic {CLRP_CODING_66, CLRP_CODING_8B} clrp_coding_e;
	typedef enum logic {CLRP_META_CRC, CLRP_META_CMD} clrp_meta_e;
	typedef enum logic [1:0] {CLRP_SYNC_WAIT, CLRP_SYNC_COUNT, CLRP_SYNC_READY} clrp_sync_e;
endpackage

// ### clrp_lane.sv
/*
 * Per-lane decode: error folding and command payload extraction.
 * Assumes PHY inputs synchronous to the core clock.
 */
`timescale 1ns/1ps
module clrp_lane
	import clrp_pkg::*;
(
	input wire logic [WORD_66-1:0] phy_lane_word_in,
	input wire logic [HDR_W-1:0] phy_lane_sync_header,
	input wire logic [BYTES_8B-1:0] phy_control_char_flags,
	input wire logic [BYTES_8B-1:0] phy_disparity_error_flags,
	input wire logic [BYTES_8B-1:0] phy_invalid_code_flags,
	input wire clrp_meta_e meta_mode,
	input wire logic [CMD_W-1:0] cmd_raw,
	output logic [BYTES_8B-1:0] byte_err,
	output logic hdr_bad,
	output logic comma_seen,
	output logic [CMD_W-1:0] cmd_word
);
	// ==========================================================
	// Folding
	always_comb begin
		byte_err = phy_disparity_error_flags | phy_invalid_code_flags;
		hdr_bad = (phy_lane_sync_header != HDR_DATA) && (phy_lane_sync_header != HDR_CTRL);
		comma_seen = phy_control_char_flags[0] && (phy_lane_word_in[7:0] == K28_5);
		if (meta_mode == CLRP_META_CRC) begin
			cmd_word = {{(CMD_W-CRC_CMD_W){1'b0}}, cmd_raw[CRC_CMD_W-1:0]};
		end else begin
			cmd_word = cmd_raw;
		end
	end
endmodule

// ### clrp_rx.sv
/*
 * Receive ports of the converter link: lane data, block markers, error
 * flags, command stream and sync request. Assumes PHY inputs, sysref and
 * user ready are synchronous to clock.
 */
`timescale 1ns/1ps
// Operation
// - Subclass 1: sysref pulse sets phase of local extended multi-block clock.
// - 8B10B: sync request low until comma alignment, then high.
// - Sync request driven only in 8B10B; held high otherwise.
// - 64B66B: 64 bits per lane, lanes concatenated on the data stream.
// - Start marker high the cycle before the first word of an extended multi-block.
// - Extended error flag on last block when alignment error seen.
// - Integrity flag on last block when CRC or FEC error in multi-block.
// - CRC meta mode: payload bits 6:0, upper bits zero.
// - Command meta mode: all 19 bits are payload.
// - Command valid for exactly one cycle per multi-block in 64B66B; never raised in 8B10B.
// - Stream reset output active low, held while core in reset.
// - Core clock is line rate over 66 or 40.
// - Core reset asynchronous; all core logic cleared by it.
module clrp_rx
	import clrp_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire clrp_pkg::clrp_coding_e coding,
	input wire clrp_pkg::clrp_meta_e meta_mode,
	input wire logic subclass1,
	input wire logic sysref,
	input wire logic [LANES*clrp_pkg::WORD_66-1:0] phy_lane_word_in,
	input wire logic [LANES*clrp_pkg::HDR_W-1:0] phy_lane_sync_header,
	input wire logic [LANES-1:0] phy_header_misaligned,
	input wire logic [LANES-1:0] phy_block_locked,
	input wire logic [LANES*clrp_pkg::BYTES_8B-1:0] phy_control_char_flags,
	input wire logic [LANES*clrp_pkg::BYTES_8B-1:0] phy_disparity_error_flags,
	input wire logic [LANES*clrp_pkg::BYTES_8B-1:0] phy_invalid_code_flags,
	input wire logic [LANES-1:0] phy_fec_uncorrectable,
	input wire logic [LANES-1:0] phy_crc_mismatch,
	input wire logic [LANES*clrp_pkg::CMD_W-1:0] phy_cmd_raw,
	input wire logic rx_cmd_tready,
	output logic rx_aresetn,
	output logic [LANES*clrp_pkg::WORD_66-1:0] rx_tdata,
	output logic rx_tvalid,
	output logic rx_soemb,
	output logic rx_emb_err,
	output logic rx_crc_err,
	output logic [LANES*clrp_pkg::BYTES_8B-1:0] rx_byte_err,
	output logic [LANES*clrp_pkg::CMD_W-1:0] rx_cmd_tdata,
	output logic rx_cmd_tvalid,
	output logic rx_sync
);
	import clrp_pkg::*;

	// ==========================================================
	// Per-lane decode
	logic [LANES*BYTES_8B-1:0] byte_err;
	logic [LANES-1:0] hdr_bad;
	logic [LANES-1:0] comma_seen;
	logic [LANES*CMD_W-1:0] cmd_word;

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : lane
			clrp_lane u_lane (
				.phy_lane_word_in(phy_lane_word_in[g*WORD_66 +: WORD_66]),
				.phy_lane_sync_header(phy_lane_sync_header[g*HDR_W +: HDR_W]),
				.phy_control_char_flags(phy_control_char_flags[g*BYTES_8B +: BYTES_8B]),
				.phy_disparity_error_flags(phy_disparity_error_flags[g*BYTES_8B +: BYTES_8B]),
				.phy_invalid_code_flags(phy_invalid_code_flags[g*BYTES_8B +: BYTES_8B]),
				.meta_mode(meta_mode),
				.cmd_raw(phy_cmd_raw[g*CMD_W +: CMD_W]),
				.byte_err(byte_err[g*BYTES_8B +: BYTES_8B]),
				.hdr_bad(hdr_bad[g]),
				.comma_seen(comma_seen[g]),
				.cmd_word(cmd_word[g*CMD_W +: CMD_W])
			);
		end
	endgenerate

	function automatic logic last_of(input logic [MB_CNT_W-1:0] c);
		return c == MB_CNT_W'(BLOCKS_PER_MB - 1);
	endfunction

	// ==========================================================
	// Block and multi-block counters
	logic [MB_CNT_W-1:0] blk_cnt, next_blk_cnt;
	logic [EMB_CNT_W-1:0] mb_cnt, next_mb_cnt;
	logic mb_err, next_mb_err;
	logic emb_err, next_emb_err;
	logic locked;
	logic emb_fault;
	logic mb_last;
	logic emb_last;
	logic emb_first_next;

	always_comb begin
		locked = &phy_block_locked;
		emb_fault = |(phy_header_misaligned | hdr_bad) || !locked;
		mb_last = last_of(blk_cnt);
		emb_last = mb_last && (mb_cnt == EMB_CNT_W'(MB_PER_EMB - 1));
		next_blk_cnt = blk_cnt + MB_CNT_W'(1);
		next_mb_cnt = mb_last ? mb_cnt + EMB_CNT_W'(1) : mb_cnt;
		if (subclass1 && sysref) begin
			next_blk_cnt = BLK_RST;
			next_mb_cnt = EMB_RST;
		end
		// Word after this one opens an extended multi-block
		emb_first_next = (next_blk_cnt == BLK_RST) && (next_mb_cnt == EMB_RST);
		next_mb_err = mb_last ? 1'b0 : mb_err;
		if (|(phy_crc_mismatch | phy_fec_uncorrectable)) begin
			next_mb_err = mb_last ? 1'b0 : 1'b1;
		end
		next_emb_err = emb_last ? 1'b0 : emb_err;
		if (emb_fault) begin
			next_emb_err = emb_last ? 1'b0 : 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			blk_cnt <= BLK_RST;
			mb_cnt <= EMB_RST;
			mb_err <= 1'b0;
			emb_err <= 1'b0;
		end else begin
			blk_cnt <= next_blk_cnt;
			mb_cnt <= next_mb_cnt;
			mb_err <= next_mb_err;
			emb_err <= next_emb_err;
		end
	end

	// ==========================================================
	// Comma alignment and sync request
	clrp_sync_e sync_st, next_sync_st;
	logic [COMMA_CNT_W-1:0] comma_cnt, next_comma_cnt;

	always_comb begin
		next_sync_st = sync_st;
		next_comma_cnt = comma_cnt;
		unique case (sync_st)
			CLRP_SYNC_WAIT: begin
				next_comma_cnt = '0;
				if (&comma_seen) begin
					next_sync_st = CLRP_SYNC_COUNT;
				end
			end
			CLRP_SYNC_COUNT: begin
				if (!(&comma_seen) || |byte_err) begin
					next_sync_st = CLRP_SYNC_WAIT;
				end else if (comma_cnt == COMMA_CNT_W'(COMMA_GOOD_WORDS - 1)) begin
					next_sync_st = CLRP_SYNC_READY;
				end else begin
					next_comma_cnt = comma_cnt + COMMA_CNT_W'(1);
				end
			end
			CLRP_SYNC_READY: begin
				if (coding != CLRP_CODING_8B) begin
					next_sync_st = CLRP_SYNC_WAIT;
				end
			end
			default: next_sync_st = CLRP_SYNC_WAIT;
		endcase
		if (coding != CLRP_CODING_8B) begin
			next_sync_st = CLRP_SYNC_WAIT;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sync_st <= CLRP_SYNC_WAIT;
			comma_cnt <= '0;
		end else begin
			sync_st <= next_sync_st;
			comma_cnt <= next_comma_cnt;
		end
	end

	// ==========================================================
	// Output registers
	logic [LANES*WORD_66-1:0] next_tdata;
	logic [LANES*BYTES_8B-1:0] next_byte_err;
	logic next_soemb, next_emb_err_o, next_crc_err, next_cmd_tvalid, next_sync;
	logic [LANES*CMD_W-1:0] next_cmd_tdata;
	logic is66;

	always_comb begin
		is66 = coding == CLRP_CODING_66;
		next_tdata = phy_lane_word_in;
		if (!is66) begin
			for (int i = 0; i < LANES; i++) begin
				next_tdata[i*WORD_66 +: WORD_66] =
					{{(WORD_66-WORD_8B){1'b0}}, phy_lane_word_in[i*WORD_66 +: WORD_8B]};
			end
		end
		next_byte_err = is66 ? '0 : byte_err;
		next_soemb = is66 && emb_first_next;
		next_emb_err_o = is66 && emb_last && (emb_err || emb_fault);
		next_crc_err = is66 && mb_last && (mb_err || |(phy_crc_mismatch | phy_fec_uncorrectable));
		next_cmd_tvalid = is66 && mb_last;
		next_cmd_tdata = mb_last ? cmd_word : rx_cmd_tdata;
		next_sync = is66 || (next_sync_st == CLRP_SYNC_READY);
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rx_aresetn <= 1'b0;
			rx_tdata <= '0;
			rx_tvalid <= 1'b0;
			rx_soemb <= 1'b0;
			rx_emb_err <= 1'b0;
			rx_crc_err <= 1'b0;
			rx_byte_err <= '0;
			rx_cmd_tdata <= '0;
			rx_cmd_tvalid <= 1'b0;
			rx_sync <= 1'b0;
		end else begin
			rx_aresetn <= 1'b1;
			rx_tdata <= next_tdata;
			rx_tvalid <= is66 ? locked : (sync_st == CLRP_SYNC_READY);
			rx_soemb <= next_soemb;
			rx_emb_err <= next_emb_err_o;
			rx_crc_err <= next_crc_err;
			rx_byte_err <= next_byte_err;
			rx_cmd_tdata <= next_cmd_tdata;
			rx_cmd_tvalid <= next_cmd_tvalid;
			rx_sync <= next_sync;
		end
	end
endmodule

// ### clrp_rx_asserts.sv
/* Checker for the receive ports: stream timing, markers, commands, sync.
   Assumes it is bound into clrp_rx and sees one clock domain. */
`timescale 1ns/1ps
module clrp_rx_asserts
	import clrp_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire clrp_pkg::clrp_coding_e coding,
	input wire clrp_pkg::clrp_meta_e meta_mode,
	input wire logic subclass1,
	input wire logic sysref,
	input wire logic [LANES*WORD_66-1:0] phy_lane_word_in,
	input wire logic [LANES-1:0] phy_block_locked,
	input wire logic [LANES*BYTES_8B-1:0] phy_control_char_flags,
	input wire logic [LANES*BYTES_8B-1:0] phy_disparity_error_flags,
	input wire logic [LANES*BYTES_8B-1:0] phy_invalid_code_flags,
	input wire logic [LANES*CMD_W-1:0] phy_cmd_raw,
	input wire logic [LANES*WORD_66-1:0] rx_tdata,
	input wire logic rx_tvalid,
	input wire logic rx_soemb,
	input wire logic rx_emb_err,
	input wire logic rx_crc_err,
	input wire logic [LANES*BYTES_8B-1:0] rx_byte_err,
	input wire logic [LANES*CMD_W-1:0] rx_cmd_tdata,
	input wire logic rx_cmd_tvalid,
	input wire logic rx_sync
);
	logic comma_ok;
	logic [47:0] hi;
	assign hi = {rx_cmd_tdata[75:64], rx_cmd_tdata[56:45], rx_cmd_tdata[37:26], rx_cmd_tdata[18:7]};
	always_comb begin
		comma_ok = ~|(phy_disparity_error_flags | phy_invalid_code_flags);
		for (int i = 0; i < LANES; i++)
			comma_ok &= phy_lane_word_in[i*64+:8] == K28_5 && phy_control_char_flags[i*4];
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// Properties
	a_cmd_pulse: assert property (rx_cmd_tvalid |=> !rx_cmd_tvalid [*8])
		else $error("command valid not a lone pulse");
	a_crc_zero: assert property (rx_cmd_tvalid && $past(meta_mode) == CLRP_META_CRC |->
		hi == 48'h0 && rx_cmd_tdata[6:0] == $past(phy_cmd_raw[6:0])) else $error("crc payload");
	a_cmd_full: assert property (rx_cmd_tvalid && $past(meta_mode) == CLRP_META_CMD |->
		rx_cmd_tdata == $past(phy_cmd_raw)) else $error("command payload");
	a_soemb_lead: assert property (rx_soemb && !$past(subclass1 && sysref) |-> rx_cmd_tvalid)
		else $error("start marker misplaced");
	a_emb_err_end: assert property (rx_emb_err |-> rx_cmd_tvalid && rx_soemb)
		else $error("extended error misplaced");
	a_tvalid_lock: assert property ($past(coding) == CLRP_CODING_66 && $past(rst_b) |->
		rx_tvalid == $past(&phy_block_locked)) else $error("valid not following lock");
	a_tvalid_sync: assert property ($past(coding) == CLRP_CODING_8B && $past(rst_b) |->
		rx_tvalid == $past(rx_sync)) else $error("valid not following sync");
	a_crc_err_end: assert property (rx_crc_err |-> rx_cmd_tvalid)
		else $error("integrity error misplaced");
	a_sysref_phase: assert property (subclass1 && sysref && coding == CLRP_CODING_66 |->
		##33 rx_cmd_tvalid) else $error("sysref phase");
	a_sync_66: assert property ($past(coding) == CLRP_CODING_66 && $past(rst_b) |-> rx_sync)
		else $error("sync low in 64b66b");
	a_sync_comma: assert property ($rose(rx_sync) && coding == CLRP_CODING_8B |->
		$past(comma_ok) && $past(comma_ok, 4)) else $error("sync rose without commas");
	a_data_delay: assert property ($past(rst_b) |-> rx_tdata == ($past(coding) == CLRP_CODING_66 ?
		$past(phy_lane_word_in) : $past(phy_lane_word_in) & {LANES{64'h0000_0000_FFFF_FFFF}}))
		else $error("data path");
	a_byte_err: assert property ($past(rst_b) |-> rx_byte_err == ($past(coding) == CLRP_CODING_8B ?
		$past(phy_disparity_error_flags | phy_invalid_code_flags) : 16'h0)) else $error("byte error");
	a_markers_8b: assert property ($past(coding) == CLRP_CODING_8B && $past(rst_b) |->
		!(rx_soemb | rx_emb_err | rx_crc_err)) else $error("marker in 8b10b");
	c_soemb: cover property (rx_soemb);
	c_emb_err: cover property (rx_emb_err);
	c_crc_err: cover property (rx_crc_err);
	c_sync_up: cover property ($rose(rx_sync));
endmodule

// ### clrp_phy_model.sv
/* Transceiver lane model: random words, comma runs, header fault.
   Assumes the bench feeds random values on the same clock. */
`timescale 1ns/1ps
module clrp_phy_model
	import clrp_pkg::*;
(
	input wire logic clock,
	input wire clrp_pkg::clrp_coding_e coding,
	input wire logic align,
	input wire logic bad_hdr,
	input wire logic [63:0] rnd,
	output logic [LANES*WORD_66-1:0] phy_lane_word_in,
	output logic [LANES*HDR_W-1:0] phy_lane_sync_header,
	output logic [LANES-1:0] phy_header_misaligned,
	output logic [LANES-1:0] phy_block_locked,
	output logic [LANES*BYTES_8B-1:0] phy_control_char_flags,
	output logic [LANES*BYTES_8B-1:0] phy_disparity_error_flags,
	output logic [LANES*BYTES_8B-1:0] phy_invalid_code_flags
);
	// ==========================================================
	// Lanes
	initial begin
		{phy_lane_word_in, phy_lane_sync_header, phy_header_misaligned, phy_block_locked} = '0;
		{phy_control_char_flags, phy_disparity_error_flags, phy_invalid_code_flags} = '0;
	end
	// Unused upper 8b10b bits carry noise so they never look quiet
	always @(posedge clock) begin
		phy_header_misaligned <= {3'h0, bad_hdr};
		phy_block_locked <= 4'hF;
		for (int i = 0; i < LANES; i++) begin
			if (coding == CLRP_CODING_66)
				phy_lane_word_in[i*64+:64] <= rnd ^ 64'(i);
			else
				phy_lane_word_in[i*64+:64] <= {rnd[63:32], align ? {24'h0, K28_5} : rnd[31:0]};
			phy_lane_sync_header[i*2+:2] <= (bad_hdr && i == 0) ? 2'h3 : HDR_DATA;
			phy_control_char_flags[i*4+:4] <= {3'h0, align};
			phy_disparity_error_flags[i*4+:4] <= align ? 4'h0 : rnd[i*4+:4];
			phy_invalid_code_flags[i*4+:4] <= align ? 4'h0 : rnd[i*4+20+:4];
		end
	end
endmodule

// ### clrp_rx_tb.sv
/* Bench for clrp_rx: random traffic, sysref, header fault, comma sync.
   Assumes the lane model and the bound checker. */
`timescale 1ns/1ps
module clrp_rx_tb;
	import clrp_pkg::*;
	logic clock = 0, rst_b = 0, subclass1 = 1, sysref = 0, rx_cmd_tready = 0;
	logic align = 0, bad_hdr = 0, en = 0, acc = 0;
	clrp_coding_e coding = CLRP_CODING_66;
	clrp_meta_e meta_mode = CLRP_META_CRC;
	logic [63:0] rnd = '0;
	logic [31:0] seed = 32'h0001_0799;
	logic [3:0] phy_fec_uncorrectable = '0, phy_crc_mismatch = '0;
	logic [3:0] phy_header_misaligned, phy_block_locked;
	logic [75:0] phy_cmd_raw = '0, rx_cmd_tdata;
	logic [255:0] phy_lane_word_in, rx_tdata;
	logic [7:0] phy_lane_sync_header;
	logic [15:0] phy_control_char_flags, phy_disparity_error_flags, phy_invalid_code_flags, rx_byte_err;
	logic rx_aresetn, rx_tvalid, rx_soemb, rx_emb_err, rx_crc_err, rx_cmd_tvalid, rx_sync;
	int error_cnt = 0, checks = 0;
	clrp_rx i_dut(.*);
	clrp_phy_model i_phy(.*);
	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task cmp_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task test_done();
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task wait_hi(input logic sel, input int n);
		for (int k = 0; k <= n; k++) begin
			@(negedge clock);
			if ((sel ? rx_emb_err : rx_sync) === 1'b1) begin
				return;
			end
		end
		error_cnt++;
		test_done();
	endtask
	initial forever #2 clock = ~clock;
	always @(posedge clock) begin
		rnd <= {xs(), xs()};
		phy_cmd_raw <= 76'({xs(), xs(), xs()});
		meta_mode <= clrp_meta_e'(seed[3]);
		rx_cmd_tready <= seed[4];
		phy_crc_mismatch <= (en && seed[15:8] == 8'h00) ? 4'h1 : 4'h0;
		phy_fec_uncorrectable <= (en && seed[23:16] == 8'h00) ? 4'h2 : 4'h0;
		acc <= (rx_cmd_tvalid === 1'b1 ? 1'b0 : acc) | (|phy_crc_mismatch) | (|phy_fec_uncorrectable);
	end
	always @(negedge clock) begin
		if (rx_cmd_tvalid === 1'b1 && en) begin
			cmp_bit(rx_crc_err, acc);
		end
	end
	// ==========================================================
	// Sequence
	initial begin
		repeat (3) @(posedge clock);
		@(negedge clock);
		cmp_bit(rx_aresetn, 1'b0);
		cmp_bit(rx_cmd_tvalid, 1'b0);
		@(posedge clock) rst_b <= 1;
		en <= 1;
		repeat (2) @(negedge clock);
		cmp_bit(rx_aresetn, 1'b1);
		repeat (2000) @(posedge clock);
		en <= 0;
		sysref <= 1;
		@(posedge clock) sysref <= 0;
		repeat (40) @(posedge clock);
		bad_hdr <= 1;
		@(posedge clock) bad_hdr <= 0;
		wait_hi(1'b1, 300);
		cmp_bit(rx_emb_err, 1'b1);
		@(negedge clock);
		cmp_bit(rx_emb_err, 1'b0);
		// Fault lands on the last block of the next extended multi-block
		repeat (125) @(posedge clock);
		bad_hdr <= 1;
		@(posedge clock) bad_hdr <= 0;
		wait_hi(1'b1, 1);
		cmp_bit(rx_emb_err, 1'b1);
		@(posedge clock) rst_b <= 0;
		coding <= CLRP_CODING_8B;
		repeat (3) @(posedge clock);
		rst_b <= 1;
		repeat (30) @(posedge clock);
		@(negedge clock);
		cmp_bit(rx_sync, 1'b0);
		@(posedge clock) align <= 1;
		repeat (6) @(negedge clock);
		cmp_bit(rx_sync, 1'b0);
		wait_hi(1'b0, 1);
		cmp_bit(rx_sync, 1'b1);
		@(posedge clock) align <= 0;
		repeat (200) @(posedge clock);
		@(negedge clock);
		cmp_bit(rx_sync, 1'b1);
		test_done();
	end
endmodule
bind clrp_rx clrp_rx_asserts i_chk(.*);
